// File: hdl/pbmc_pkg.sv
package pbmc_pkg;
    localparam logic [4:0]  BMC_ADDR      = 5'h00;
    localparam int          BIT_RESET     = 15;
    localparam int          BIT_LOOP      = 14;
    localparam int          BIT_SPEED     = 13;
    localparam int          BIT_ANEN      = 12;
    localparam int          BIT_PDOWN     = 11;
    localparam int          BIT_ISOLATE   = 10;
    localparam int          BIT_RESTART   = 9;
    localparam int          BIT_DUPLEX    = 8;
    localparam int          BIT_COLTEST   = 7;
    localparam logic [15:0] BMC_RESET_VAL = 16'h3100;
    localparam logic [15:0] BMC_RW_MASK   = 16'h7F80;
    localparam int          CLK_HZ        = 50_000_000;
    localparam int          SRST_CYCLES   = 16;
    localparam int          DEAD_TIME_MS  = 720;
    localparam int          DEAD_CYCLES   = (CLK_HZ / 1000) * DEAD_TIME_MS;
endpackage

// File: hdl/pbmc_basic_mode_control.sv
`timescale 1ns/1ns
module pbmc_basic_mode_control
#(
    parameter int DEAD_CYCLES = pbmc_pkg::DEAD_CYCLES,
    parameter int SRST_CYCLES = pbmc_pkg::SRST_CYCLES
)
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        mgmt_wr_i,
    input  wire logic        mgmt_rd_i,
    input  wire logic [4:0]  mgmt_addr_i,
    input  wire logic [15:0] mgmt_wdata_i,
    output logic      [15:0] mgmt_rdata_o,
    output logic             mgmt_hit_o,
    input  wire logic        an_started_i,
    input  wire logic        an_speed100_i,
    input  wire logic        an_full_duplex_i,
    input  wire logic        mii_tx_en_i,
    input  wire logic        mii_col_i,
    input  wire logic        mii_rx_dv_i,
    output logic             mii_col_o,
    output logic             mii_rx_dv_o,
    output logic             phy_soft_reset_o,
    output logic             an_restart_o,
    output logic             loopback_o,
    output logic             speed100_o,
    output logic             full_duplex_o,
    output logic             an_enable_o,
    output logic             power_down_o,
    output logic             isolate_o
);
    // =====================================================
    // decode
    localparam int CW = $clog2(DEAD_CYCLES + 1);
    localparam int SW = $clog2(SRST_CYCLES + 1);
    logic [15:0]   ctl_q;
    logic [15:0]   ctl_d;
    logic [SW-1:0] srst_cnt_q;
    logic [SW-1:0] srst_cnt_d;
    logic [CW-1:0] dead_cnt_q;
    logic [CW-1:0] dead_cnt_d;
    logic          rst_busy_q;
    logic          rst_busy_d;
    logic          restart_q;
    logic          restart_d;
    logic          col_q;
    logic          rxdv_q;
    wire           hit     = (mgmt_addr_i == pbmc_pkg::BMC_ADDR);
    wire           wr_hit  = mgmt_wr_i && hit && !rst_busy_q;
    wire           an_on   = ctl_q[pbmc_pkg::BIT_ANEN];
    wire           loop_up = wr_hit && mgmt_wdata_i[pbmc_pkg::BIT_LOOP] && !ctl_q[pbmc_pkg::BIT_LOOP]
                             && speed100_o;
    wire           dead    = (dead_cnt_q != '0);
    // =====================================================
    // state
    always_comb
    begin
        ctl_d      = ctl_q;
        rst_busy_d = rst_busy_q;
        srst_cnt_d = srst_cnt_q;
        restart_d  = restart_q;
        dead_cnt_d = dead_cnt_q;
        if (dead)
            dead_cnt_d = dead_cnt_q - CW'(1);
        if (loop_up)
            dead_cnt_d = CW'(DEAD_CYCLES);
        if (restart_q && (an_started_i || !an_on))
            restart_d = 1'b0;
        if (wr_hit)
        begin
            ctl_d = mgmt_wdata_i & pbmc_pkg::BMC_RW_MASK;
            // a written zero clears restart_q too, so an_restart_o drops at once
            if (mgmt_wdata_i[pbmc_pkg::BIT_RESTART] && mgmt_wdata_i[pbmc_pkg::BIT_ANEN])
                restart_d = 1'b1;
            else if (!mgmt_wdata_i[pbmc_pkg::BIT_RESTART])
                restart_d = 1'b0;
            if (mgmt_wdata_i[pbmc_pkg::BIT_RESET])
            begin
                rst_busy_d = 1'b1;
                srst_cnt_d = SW'(SRST_CYCLES);
            end
        end
        if (rst_busy_q)
        begin
            ctl_d      = pbmc_pkg::BMC_RESET_VAL;
            restart_d  = 1'b0;
            dead_cnt_d = '0;
            srst_cnt_d = srst_cnt_q - SW'(1);
            if (srst_cnt_q == SW'(1))
                rst_busy_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctl_q      <= pbmc_pkg::BMC_RESET_VAL;
            rst_busy_q <= 1'b0;
            srst_cnt_q <= '0;
            restart_q  <= 1'b0;
            dead_cnt_q <= '0;
        end
        else
        begin
            ctl_q      <= ctl_d;
            rst_busy_q <= rst_busy_d;
            srst_cnt_q <= srst_cnt_d;
            restart_q  <= restart_d;
            dead_cnt_q <= dead_cnt_d;
        end
    end
    // =====================================================
    // read back and mii gating
    wire spd_rd = an_on ? an_speed100_i : ctl_q[pbmc_pkg::BIT_SPEED];
    wire fdx_rd = an_on ? an_full_duplex_i : ctl_q[pbmc_pkg::BIT_DUPLEX];
    wire [15:0] rd_word = {rst_busy_q, ctl_q[pbmc_pkg::BIT_LOOP], spd_rd, an_on,
                           ctl_q[pbmc_pkg::BIT_PDOWN], ctl_q[pbmc_pkg::BIT_ISOLATE], restart_q,
                           fdx_rd, ctl_q[pbmc_pkg::BIT_COLTEST], 7'h00};
    wire pd = ctl_q[pbmc_pkg::BIT_PDOWN];
    // registered so mii outputs never glitch into power-down
    wire col_n  = !pd && (mii_col_i || (ctl_q[pbmc_pkg::BIT_COLTEST] && mii_tx_en_i));
    // the enabling write itself already blanks receive valid, so the dead time starts at once
    wire rxdv_n = !pd && !dead && !loop_up && mii_rx_dv_i;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            col_q        <= 1'b0;
            rxdv_q       <= 1'b0;
            mgmt_rdata_o <= 16'h0000;
        end
        else
        begin
            col_q  <= col_n;
            rxdv_q <= rxdv_n;
            // answers still while powered down
            if (mgmt_rd_i && hit)
                mgmt_rdata_o <= rd_word;
        end
    end

    assign mgmt_hit_o       = hit;
    assign mii_col_o        = col_q;
    assign mii_rx_dv_o      = rxdv_q;
    assign phy_soft_reset_o = rst_busy_q;
    assign an_restart_o     = restart_q;
    assign loopback_o       = ctl_q[pbmc_pkg::BIT_LOOP];
    assign speed100_o       = spd_rd;
    assign full_duplex_o    = fdx_rd;
    assign an_enable_o      = an_on;
    assign power_down_o     = pd;
    assign isolate_o        = ctl_q[pbmc_pkg::BIT_ISOLATE];

    // =====================================================
    // checks
    chk_reset_defaults: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(rst_busy_q) |-> ctl_q == pbmc_pkg::BMC_RESET_VAL) else $error("soft reset defaults");
    chk_reset_reads_one: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_hit && mgmt_wdata_i[15] |=> rst_busy_q [*4]) else $error("reset bit dropped early");
    chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mgmt_rd_i && hit |=> mgmt_rdata_o[6:0] == 7'h00) else $error("reserved bits nonzero");
    chk_speed_from_an: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mgmt_rd_i && hit && an_on |=> mgmt_rdata_o[13] == $past(an_speed100_i)) else $error("speed read");
    chk_duplex_manual: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !an_on |-> full_duplex_o == ctl_q[8]) else $error("duplex manual");
    chk_coltest_col: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ctl_q[7] && !pd && mii_tx_en_i |=> mii_col_o) else $error("collision test");
    chk_pdown_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        pd && $past(pd) |-> !mii_col_o && !mii_rx_dv_o) else $error("mii active in power down");
    chk_restart_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        restart_q && an_started_i && !wr_hit |=> !restart_q) else $error("restart not cleared");
    chk_dead_time: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        loop_up && !rst_busy_q |=> !mii_rx_dv_o [*4]) else $error("dead time");
    cov_soft_reset: cover property (@(posedge sys_clk_i) disable iff (rst_i) $fell(rst_busy_q));
    cov_restart: cover property (@(posedge sys_clk_i) disable iff (rst_i) $fell(restart_q));
    cov_loop_dead: cover property (@(posedge sys_clk_i) disable iff (rst_i) loop_up);
endmodule

// File: testbench/pbmc_sme_model.sv
`timescale 1ns/1ns
module pbmc_sme_model
(
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic [4:0]       addr_o,
    output logic [15:0]      wdata_o
);
    initial
    begin
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = 5'h1F;
        wdata_o = 16'h0000;
    end
    // released address and data lines show the inverse so stale data never looks valid; wr_o and rd_o go low
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        #2;
        wr_o    = w;
        rd_o    = ~w;
        addr_o  = a;
        wdata_o = d;
        @(posedge clk_i);
        #2;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
        q       = rdata_i;
    endtask
endmodule

// File: testbench/tb_phy_basic_mode_control.sv
`timescale 1ns/1ns
`define CMP(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_phy_basic_mode_control;
    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        wr, rd, hit, col_o, dv_o;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, rv;
    logic        an_st = 1'b0, an_spd = 1'b0, an_fdx = 1'b0, tx_en = 1'b0, rx_dv = 1'b0;
    int          err_total = 0;
    int          checked   = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    pbmc_sme_model pbmc_sme_model_inst (.clk_i(sys_clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wdata));
    pbmc_basic_mode_control #(.DEAD_CYCLES(20), .SRST_CYCLES(4)) pbmc_basic_mode_control_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_addr_i(addr),
        .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .mgmt_hit_o(hit), .an_started_i(an_st),
        .an_speed100_i(an_spd), .an_full_duplex_i(an_fdx), .mii_tx_en_i(tx_en), .mii_col_i(1'b0),
        .mii_rx_dv_i(rx_dv), .mii_col_o(col_o), .mii_rx_dv_o(dv_o), .phy_soft_reset_o(),
        .an_restart_o(), .loopback_o(), .speed100_o(), .full_duplex_o(), .an_enable_o(),
        .power_down_o(), .isolate_o());
    task automatic wr_reg(input logic [15:0] d);
        pbmc_sme_model_inst.xfer(1'b1, 5'h00, d, rv);
    endtask
    task automatic rd_reg(input logic [4:0] a);
        pbmc_sme_model_inst.xfer(1'b0, a, 16'h0000, rv);
    endtask
    task automatic t_defaults;
        rd_reg(5'h00);
        `CMP("dflt", 16'h1000, rv)
        rd_reg(5'h01);
        `CMP("miss", 16'h1000, rv)
    endtask
    task automatic t_fields;
        rx_dv = 1'b1;
        wr_reg(16'h41FF);
        rd_reg(5'h00);
        `CMP("rw", 16'h4180, rv)
        tx_en = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #2;
        `CMP("coltest", 1'b1, col_o)
        tx_en = 1'b0;
        wr_reg(16'h2000);
        rd_reg(5'h00);
        `CMP("speed", 16'h2000, rv)
        wr_reg(16'h6000);
        repeat (3) @(posedge sys_clk_i);
        `CMP("dead", 1'b0, dv_o)
        repeat (25) @(posedge sys_clk_i);
        `CMP("alive", 1'b1, dv_o)
    endtask
    task automatic t_restart;
        wr_reg(16'h0200);
        rd_reg(5'h00);
        `CMP("rst_off", 16'h0000, rv)
        wr_reg(16'h1200);
        rd_reg(5'h00);
        `CMP("restart", 16'h1200, rv)
        an_st = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd_reg(5'h00);
        `CMP("started", 16'h1000, rv)
        an_st  = 1'b0;
        an_spd = 1'b1;
        an_fdx = 1'b1;
        rd_reg(5'h00);
        `CMP("an_stat", 16'h3100, rv)
    endtask
    task automatic t_pdown;
        wr_reg(16'h0800);
        repeat (2) @(posedge sys_clk_i);
        `CMP("pd_dv", 1'b0, dv_o)
        rd_reg(5'h00);
        `CMP("pd_rd", 16'h0800, rv)
        rx_dv = 1'b0;
    endtask
    task automatic t_swreset;
        wr_reg(16'h8000);
        rd_reg(5'h00);
        `CMP("busy", 1'b1, rv[15])
        repeat (8) @(posedge sys_clk_i);
        rd_reg(5'h00);
        `CMP("sw_dflt", 16'h3100, rv)
    endtask
    task automatic final_report;
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // guard against a hang anywhere in the sequence
    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        err_total++;
        final_report();
    end
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        #2;
        rst_i = 1'b0;
        t_defaults();
        t_fields();
        t_restart();
        t_pdown();
        t_swreset();
        final_report();
    end
endmodule
